// ---- src/gpio_cfg_pkg.sv ----
// Constants and types for the GPIO command and readback block.
package gpio_cfg_pkg;
  localparam int NUM_PINS      = 5;
  localparam int PIN_IDX_W     = 3;
  localparam int CLK_HZ        = 50_000_000;
  localparam int SAMPLE_HZ     = 32;
  localparam int PWM_HZ        = 100;
  localparam int PWM_STEPS     = 100;
  localparam int SAMPLE_DIV    = CLK_HZ / SAMPLE_HZ;
  localparam int PWM_STEP_DIV  = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int PIN_PWR_SENSE = 1;
  localparam int PIN_PWR_CTL   = 2;
  localparam int PIN_RST_CTL   = 3;
  localparam int PIN_ONE_WIRE  = 4;

  localparam logic [7:0] CMD_STORE_BOOT = 8'h04;
  localparam logic [7:0] CMD_SET_PIN    = 8'h22;
  localparam logic [7:0] CMD_READ_PIN   = 8'h23;
  localparam logic [7:0] REPLY_ACK      = 8'h40;
  localparam logic [7:0] REPLY_ERR      = 8'hC0;

  localparam logic [3:0] LEN_NONE       = 4'h0;
  localparam logic [3:0] LEN_PIN        = 4'h1;
  localparam logic [3:0] LEN_VALUE      = 4'h2;
  localparam logic [3:0] LEN_VALUE_CFG  = 4'h3;
  localparam logic [3:0] LEN_READ_REPLY = 4'h4;

  localparam logic [7:0] LEVEL_LOW  = 8'h00;
  localparam logic [7:0] LEVEL_HIGH = 8'h64;

  localparam logic [2:0] DRV_FAST_PD  = 3'h0;
  localparam logic [2:0] DRV_FAST_PP  = 3'h1;
  localparam logic [2:0] DRV_HIZ      = 3'h2;
  localparam logic [2:0] DRV_PU_FAST  = 3'h3;
  localparam logic [2:0] DRV_SLOW_HIZ = 3'h4;
  localparam logic [2:0] DRV_SLOW_PP  = 3'h5;
  localparam logic [2:0] DRV_RESERVED = 3'h6;
  localparam logic [2:0] DRV_HIZ_SLOW = 3'h7;

  localparam logic [11:0] ADDR_ARG        = 12'h000;
  localparam logic [11:0] ADDR_CMD        = 12'h004;
  localparam logic [11:0] ADDR_REPLY_HDR  = 12'h008;
  localparam logic [11:0] ADDR_REPLY_DATA = 12'h00C;
  localparam logic [11:0] ADDR_LEVELS     = 12'h010;

  typedef struct packed {
    logic       func;
    logic [2:0] drive;
  } pin_cfg_t;

  typedef struct packed {
    logic [3:0] rsvd;
    pin_cfg_t   cfg;
  } cfg_byte_t;

  typedef struct packed {
    logic [7:0] rsvd;
    cfg_byte_t  cfg;
    logic [7:0] level;
    logic [7:0] pin;
  } arg_word_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic [3:0]  len;
    logic [7:0]  code;
  } cmd_word_t;

  typedef struct packed {
    logic [18:0] rsvd;
    logic        valid;
    logic [3:0]  len;
    logic [7:0]  code;
  } reply_hdr_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic       rise;
    logic       fall;
    logic       level;
  } pin_state_edge_byte_t;

  typedef struct packed {
    cfg_byte_t            cfg;
    logic [7:0]           level;
    pin_state_edge_byte_t status;
    logic [7:0]           pin;
  } reply_data_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_dn;
    logic slow;
  } pad_drive_t;

  localparam pin_cfg_t [NUM_PINS-1:0] DFLT_CFG = {4'h3, 4'h1, 4'h1, 4'h2, 4'h2};
endpackage : gpio_cfg_pkg

// ---- src/pin_sampler.sv ----
// Pin synchroniser, periodic sampler and sticky edge flags.
`timescale 1ns/10ps
module pin_sampler #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // Pins, sample strobe and flag clears
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] clr,
  // Sampled state
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] fall,
  output logic      [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] fall_ff;
  logic [WIDTH-1:0] rise_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      level_ff <= '0;
    end else if (tick) begin
      level_ff <= sync_ff;
    end
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_flag
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        fall_ff[i] <= 1'b0;
        rise_ff[i] <= 1'b0;
      end else begin
        if (tick && level_ff[i] && !sync_ff[i]) begin
          fall_ff[i] <= 1'b1;
        end else if (clr[i]) begin
          fall_ff[i] <= 1'b0;
        end
        if (tick && !level_ff[i] && sync_ff[i]) begin
          rise_ff[i] <= 1'b1;
        end else if (clr[i]) begin
          rise_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign level = level_ff;
  assign fall  = fall_ff;
  assign rise  = rise_ff;
endmodule : pin_sampler

// ---- src/gpio_command_config_readback.sv ----
// GPIO set and read command engine with APB access, PWM and pad drive.
`timescale 1ns/10ps
module gpio_command_config_readback #(
  parameter int SAMPLE_DIV_P   = gpio_cfg_pkg::SAMPLE_DIV,
  parameter int PWM_STEP_DIV_P = gpio_cfg_pkg::PWM_STEP_DIV
) (
  // Clock and resets
  input  wire logic                                        clock,
  input  wire logic                                        nrst,
  input  wire logic                                        npor,
  // APB slave
  input  wire logic [11:0]                                 paddr,
  input  wire logic                                        psel,
  input  wire logic                                        penable,
  input  wire logic                                        pwrite,
  input  wire logic [31:0]                                 pwdata,
  output logic      [31:0]                                 prdata,
  output logic                                             pready,
  output logic                                             pslverr,
  // Pins
  input  wire logic [gpio_cfg_pkg::NUM_PINS-1:0]           pin_in,
  output gpio_cfg_pkg::pad_drive_t [gpio_cfg_pkg::NUM_PINS-1:0] pad_drive,
  // Default roles
  input  wire logic                                        host_power_ctl,
  input  wire logic                                        host_reset_ctl,
  input  wire logic                                        one_wire_tx,
  output logic                                             host_power_sense,
  output logic                                             one_wire_rx
);
  import gpio_cfg_pkg::*;

  localparam int SAMPLE_W = $clog2(SAMPLE_DIV_P);
  localparam int STEP_W   = $clog2(PWM_STEP_DIV_P);
  localparam logic [SAMPLE_W-1:0] SAMPLE_LAST = SAMPLE_W'(SAMPLE_DIV_P - 1);
  localparam logic [STEP_W-1:0]   STEP_LAST   = STEP_W'(PWM_STEP_DIV_P - 1);
  localparam logic [6:0]          PWM_LAST    = 7'(PWM_STEPS - 1);

  if (SAMPLE_DIV_P < 16) begin : g_chk_sample
    $error("SAMPLE_DIV_P must be at least 16");
  end
  if (PWM_STEP_DIV_P < 2) begin : g_chk_step
    $error("PWM_STEP_DIV_P must be at least 2");
  end

  logic [31:0]                      prdata_ff;
  logic                             pready_ff;
  logic                             pslverr_ff;
  arg_word_t                        arg_ff;
  cmd_word_t                        last_cmd_ff;
  reply_hdr_t                       reply_hdr_ff;
  reply_data_t                      reply_data_ff;
  pin_cfg_t   [NUM_PINS-1:0]        cfg_ff;
  logic       [NUM_PINS-1:0][7:0]   val_ff;
  pin_cfg_t   [NUM_PINS-1:0]        boot_cfg_ff;
  logic       [NUM_PINS-1:0][7:0]   boot_val_ff;
  logic                             restore_ff;
  pad_drive_t [NUM_PINS-1:0]        pad_ff;
  logic [SAMPLE_W-1:0]              sample_cnt_ff;
  logic                             tick_ff;
  logic [STEP_W-1:0]                step_cnt_ff;
  logic [6:0]                       pwm_cnt_ff;

  logic                  access_start;
  logic                  done;
  logic                  wr_done;
  logic                  rd_done;
  logic                  addr_hit;
  logic [31:0]           rd_word;
  cmd_word_t             cmd_in;
  logic                  cmd_go;
  logic                  pin_ok;
  logic                  level_ok;
  logic                  set_ok;
  logic                  read_ok;
  logic                  store_ok;
  logic [PIN_IDX_W-1:0]  sel_pin;
  logic [NUM_PINS-1:0]   level_w;
  logic [NUM_PINS-1:0]   fall_w;
  logic [NUM_PINS-1:0]   rise_w;
  logic [NUM_PINS-1:0]   edge_clr;
  logic [NUM_PINS-1:0]   pwm_bit;
  logic [NUM_PINS-1:0]   pin_level;
  logic [NUM_PINS-1:0]   dflt_level;

  function automatic pad_drive_t drive_pad(input pin_cfg_t cfg, input logic lvl);
    pad_drive_t p;
    p = '0;
    case (cfg.drive)
      DRV_FAST_PD: begin
        p.oe      = lvl;
        p.out     = 1'b1;
        p.pull_dn = !lvl;
      end
      DRV_FAST_PP: begin
        p.oe  = 1'b1;
        p.out = lvl;
      end
      DRV_PU_FAST: begin
        p.oe      = !lvl;
        p.pull_up = lvl;
      end
      DRV_SLOW_HIZ: begin
        p.oe   = lvl;
        p.out  = 1'b1;
        p.slow = 1'b1;
      end
      DRV_SLOW_PP: begin
        p.oe   = 1'b1;
        p.out  = lvl;
        p.slow = 1'b1;
      end
      DRV_HIZ_SLOW: begin
        p.oe   = !lvl;
        p.slow = 1'b1;
      end
      default: begin
        p = '0;
      end
    endcase
    return p;
  endfunction : drive_pad

  // APB answers one cycle into the access phase.
  assign access_start = psel && penable && !pready_ff;
  assign done         = psel && penable && pready_ff;
  assign wr_done      = done && pwrite;
  assign rd_done      = done && !pwrite;

  always_comb begin
    addr_hit = 1'b1;
    rd_word  = '0;
    case (paddr)
      ADDR_ARG:        rd_word = arg_ff;
      ADDR_CMD:        rd_word = last_cmd_ff;
      ADDR_REPLY_HDR:  rd_word = reply_hdr_ff;
      ADDR_REPLY_DATA: rd_word = reply_data_ff;
      ADDR_LEVELS:     rd_word = 32'(level_w);
      default:         addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= access_start;
      if (access_start) begin
        prdata_ff  <= pwrite ? '0 : rd_word;
        pslverr_ff <= !addr_hit;
      end
    end
  end

  // Command decode.
  assign cmd_in   = cmd_word_t'(pwdata);
  assign cmd_go   = wr_done && (paddr == ADDR_CMD);
  assign sel_pin  = arg_ff.pin[PIN_IDX_W-1:0];
  assign pin_ok   = arg_ff.pin < 8'(NUM_PINS);
  assign level_ok = arg_ff.level <= LEVEL_HIGH;
  assign set_ok   = cmd_go && (cmd_in.code == CMD_SET_PIN) && pin_ok && level_ok
                    && ((cmd_in.len == LEN_VALUE) || (cmd_in.len == LEN_VALUE_CFG));
  assign read_ok  = cmd_go && (cmd_in.code == CMD_READ_PIN) && pin_ok
                    && (cmd_in.len == LEN_PIN);
  assign store_ok = cmd_go && (cmd_in.code == CMD_STORE_BOOT) && (cmd_in.len == LEN_NONE);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      arg_ff      <= '0;
      last_cmd_ff <= '0;
    end else begin
      if (wr_done && (paddr == ADDR_ARG)) begin
        arg_ff <= arg_word_t'(pwdata);
      end
      if (cmd_go) begin
        last_cmd_ff <= cmd_in;
      end
    end
  end

  // Working configuration, restored from the boot image after reset.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_ff     <= DFLT_CFG;
      val_ff     <= '0;
      restore_ff <= 1'b1;
    end else if (restore_ff) begin
      cfg_ff     <= boot_cfg_ff;
      val_ff     <= boot_val_ff;
      restore_ff <= 1'b0;
    end else if (set_ok) begin
      val_ff[sel_pin] <= arg_ff.level;
      if (cmd_in.len == LEN_VALUE_CFG) begin
        cfg_ff[sel_pin] <= arg_ff.cfg.cfg;
      end
    end
  end

  // Boot image survives the ordinary reset.
  always_ff @(posedge clock or negedge npor) begin
    if (!npor) begin
      boot_cfg_ff <= DFLT_CFG;
      boot_val_ff <= '0;
    end else if (store_ok) begin
      boot_cfg_ff <= cfg_ff;
      boot_val_ff <= val_ff;
    end
  end

  // Reply header and data.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reply_hdr_ff  <= '0;
      reply_data_ff <= '0;
    end else if (cmd_go) begin
      reply_hdr_ff.valid <= 1'b1;
      reply_hdr_ff.len   <= LEN_NONE;
      if (set_ok) begin
        reply_hdr_ff.code <= CMD_SET_PIN | REPLY_ACK;
      end else if (read_ok) begin
        reply_hdr_ff.code           <= CMD_READ_PIN | REPLY_ACK;
        reply_hdr_ff.len            <= LEN_READ_REPLY;
        reply_data_ff.pin           <= arg_ff.pin;
        reply_data_ff.status        <= '0;
        reply_data_ff.status.level  <= level_w[sel_pin];
        reply_data_ff.status.fall   <= fall_w[sel_pin];
        reply_data_ff.status.rise   <= rise_w[sel_pin];
        reply_data_ff.level         <= val_ff[sel_pin];
        reply_data_ff.cfg           <= '0;
        reply_data_ff.cfg.cfg       <= cfg_ff[sel_pin];
      end else if (store_ok) begin
        reply_hdr_ff.code <= CMD_STORE_BOOT | REPLY_ACK;
      end else begin
        reply_hdr_ff.code <= cmd_in.code | REPLY_ERR;
      end
    end else if (rd_done && (paddr == ADDR_REPLY_HDR)) begin
      reply_hdr_ff.valid <= 1'b0;
    end
  end

  // Sample strobe.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sample_cnt_ff <= '0;
      tick_ff       <= 1'b0;
    end else begin
      tick_ff <= (sample_cnt_ff == SAMPLE_LAST);
      if (sample_cnt_ff == SAMPLE_LAST) begin
        sample_cnt_ff <= '0;
      end else begin
        sample_cnt_ff <= sample_cnt_ff + 1'b1;
      end
    end
  end

  // PWM step counter, 0 to 99.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      step_cnt_ff <= '0;
      pwm_cnt_ff  <= '0;
    end else if (step_cnt_ff == STEP_LAST) begin
      step_cnt_ff <= '0;
      pwm_cnt_ff  <= (pwm_cnt_ff == PWM_LAST) ? '0 : pwm_cnt_ff + 1'b1;
    end else begin
      step_cnt_ff <= step_cnt_ff + 1'b1;
    end
  end

  pin_sampler #(
    .WIDTH (NUM_PINS)
  ) u_sampler (
    .clock  (clock),
    .nrst   (nrst),
    .pin_in (pin_in),
    .tick   (tick_ff),
    .clr    (edge_clr),
    .level  (level_w),
    .fall   (fall_w),
    .rise   (rise_w)
  );

  // Default role levels per pin.
  always_comb begin
    dflt_level               = '0;
    dflt_level[PIN_PWR_CTL]  = host_power_ctl;
    dflt_level[PIN_RST_CTL]  = host_reset_ctl;
    dflt_level[PIN_ONE_WIRE] = one_wire_tx;
  end

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    assign pwm_bit[i]   = {1'b0, pwm_cnt_ff} < val_ff[i];
    assign pin_level[i] = cfg_ff[i].func ? pwm_bit[i] : dflt_level[i];
    assign edge_clr[i]  = read_ok && (sel_pin == PIN_IDX_W'(i));

    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        pad_ff[i] <= '0;
      end else begin
        pad_ff[i] <= drive_pad(cfg_ff[i], pin_level[i]);
      end
    end

    property p_level_ends;
      @(posedge clock) disable iff (!nrst)
      ((val_ff[i] == LEVEL_HIGH) |-> pwm_bit[i]) and ((val_ff[i] == LEVEL_LOW) |-> !pwm_bit[i]);
    endproperty
    a_level_ends: assert property (p_level_ends) else $error("level 0 or 100 not steady");

    property p_fast_strong;
      @(posedge clock) disable iff (!nrst)
      (cfg_ff[i].drive == DRV_FAST_PP) |=> pad_ff[i].oe && !pad_ff[i].slow
                                          && (pad_ff[i].out == $past(pin_level[i]));
    endproperty
    a_fast_strong: assert property (p_fast_strong) else $error("fast push-pull wrong");

    property p_slow_low;
      @(posedge clock) disable iff (!nrst)
      (cfg_ff[i].drive == DRV_HIZ_SLOW) |=> pad_ff[i].slow
                                           && (pad_ff[i].oe == !$past(pin_level[i]));
    endproperty
    a_slow_low: assert property (p_slow_low) else $error("slow low-only drive wrong");

    property p_hiz_input;
      @(posedge clock) disable iff (!nrst)
      (cfg_ff[i].drive == DRV_HIZ) |=> !pad_ff[i].oe && !pad_ff[i].pull_up && !pad_ff[i].pull_dn;
    endproperty
    a_hiz_input: assert property (p_hiz_input) else $error("input mode drives pin");
  end

  // Outputs.
  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign pad_drive        = pad_ff;
  assign host_power_sense = level_w[PIN_PWR_SENSE];
  assign one_wire_rx      = level_w[PIN_ONE_WIRE];

  sequence s_set_value;
    set_ok && (cmd_in.len == LEN_VALUE);
  endsequence

  sequence s_set_cfg;
    set_ok && (cmd_in.len == LEN_VALUE_CFG);
  endsequence

  sequence s_read;
    read_ok;
  endsequence

  property p_set_ack;
    @(posedge clock) disable iff (!nrst)
    set_ok |=> reply_hdr_ff.valid && (reply_hdr_ff.code == (CMD_SET_PIN | REPLY_ACK))
               && (reply_hdr_ff.len == LEN_NONE);
  endproperty
  a_set_ack: assert property (p_set_ack) else $error("set command not acknowledged");

  property p_value_only;
    @(posedge clock) disable iff (!nrst)
    s_set_value |=> (val_ff[$past(sel_pin)] == $past(arg_ff.level)) && (cfg_ff == $past(cfg_ff));
  endproperty
  a_value_only: assert property (p_value_only) else $error("two-byte set wrong");

  property p_set_cfg;
    @(posedge clock) disable iff (!nrst)
    s_set_cfg |=> cfg_ff[$past(sel_pin)] == $past(arg_ff.cfg.cfg);
  endproperty
  a_set_cfg: assert property (p_set_cfg) else $error("three-byte set wrong");

  property p_bad_pin;
    @(posedge clock) disable iff (!nrst)
    (cmd_go && !pin_ok && !store_ok) |=> $stable(cfg_ff) && $stable(val_ff)
                                          && ((reply_hdr_ff.code & REPLY_ERR) == REPLY_ERR);
  endproperty
  a_bad_pin: assert property (p_bad_pin) else $error("reserved pin index accepted");

  property p_read_reply;
    @(posedge clock) disable iff (!nrst)
    s_read |=> (reply_data_ff.pin == $past(arg_ff.pin))
               && (reply_data_ff.status.level == $past(level_w[sel_pin]))
               && (reply_data_ff.level == $past(val_ff[sel_pin]))
               && (reply_hdr_ff.len == LEN_READ_REPLY);
  endproperty
  a_read_reply: assert property (p_read_reply) else $error("read reply wrong");

  property p_cfg_readback;
    @(posedge clock) disable iff (!nrst)
    s_read |=> (reply_data_ff.cfg.rsvd == '0) && (reply_data_ff.cfg.cfg == $past(cfg_ff[sel_pin]));
  endproperty
  a_cfg_readback: assert property (p_cfg_readback) else $error("config readback wrong");

  property p_read_clears;
    @(posedge clock) disable iff (!nrst)
    (s_read ##0 !tick_ff) |=> !fall_w[$past(sel_pin)] && !rise_w[$past(sel_pin)];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("edge flags not cleared");

  property p_tick_spacing;
    @(posedge clock) disable iff (!nrst)
    tick_ff |=> !tick_ff [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("sample strobe too fast");

  property p_restore;
    @(posedge clock) disable iff (!nrst)
    restore_ff |=> (cfg_ff == $past(boot_cfg_ff)) && (val_ff == $past(boot_val_ff)) && !restore_ff;
  endproperty
  a_restore: assert property (p_restore) else $error("boot image not restored");
endmodule : gpio_command_config_readback

// ---- verification/pin_load_model.sv ----
// Pin load model that resolves pad drive and an external source into pin levels.
`timescale 1ns/10ps
module pin_load_model (
  // Pad drive and external source
  input  wire gpio_cfg_pkg::pad_drive_t [4:0] pad_drive,
  input  wire logic                           ext,
  // Resolved pin levels
  output logic                        [4:0] pin_in
);
  import gpio_cfg_pkg::*;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_in[i] = pad_drive[i].oe ? pad_drive[i].out :
                  pad_drive[i].pull_up | (~pad_drive[i].pull_dn & ext);
    end
  end
endmodule : pin_load_model

// ---- verification/gpio_command_config_readback_tb.sv ----
// Testbench for the GPIO command and readback block.
`timescale 1ns/10ps
module gpio_command_config_readback_tb;
  import gpio_cfg_pkg::*;
  logic             clock, nrst, npor, psel, penable, pwrite, pready, pslverr, ext, hpc, err;
  logic             hps, owr;
  logic [3:0]       pe;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [4:0]       pin_in;
  pad_drive_t [4:0] pad_drive;
  pad_drive_t       pd;
  int               bad_count, checks_done, cyc, n;

  gpio_command_config_readback #(.SAMPLE_DIV_P(32), .PWM_STEP_DIV_P(4)) uut (
    .clock(clock), .nrst(nrst), .npor(npor), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pad_drive(pad_drive),
    .host_power_ctl(hpc), .host_reset_ctl(hpc), .one_wire_tx(ext),
    .host_power_sense(hps), .one_wire_rx(owr));
  pin_load_model load (.pad_drive(pad_drive), .ext(ext), .pin_in(pin_in));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic cmd(input logic [31:0] arg, input logic [7:0] code, input logic [3:0] len);
    bus(1'b1, ADDR_ARG, arg);
    bus(1'b1, ADDR_CMD, {20'h0_0000, len, code});
    bus(1'b0, ADDR_REPLY_HDR, 32'h0000_0000);
  endtask : cmd

  task automatic set(input logic [7:0] p, input logic [7:0] lv, input logic [3:0] c);
    cmd({12'h000, c, lv, p}, CMD_SET_PIN, LEN_VALUE_CFG);
    chk(rd[12:0], {1'b1, LEN_NONE, 8'h62});
  endtask : set

  task automatic get(input logic [7:0] p);
    cmd({24'h00_0000, p}, CMD_READ_PIN, LEN_PIN);
    chk(rd[12:0], {1'b1, LEN_READ_REPLY, 8'h63});
    bus(1'b0, ADDR_REPLY_DATA, 32'h0000_0000);
    chk(rd[7:0], p);
  endtask : get

  task automatic rst(input logic por);
    nrst <= 1'b0;
    npor <= ~por;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    npor <= 1'b1;
  endtask : rst

  function automatic logic [3:0] pad_exp(input logic [2:0] d, input logic h);
    case (d)
      3'h0: pad_exp = h ? 4'hC : 4'h1;
      3'h1: pad_exp = {1'b1, h, 2'h0};
      3'h3: pad_exp = h ? 4'h2 : 4'h8;
      3'h4: pad_exp = h ? 4'hC : 4'h0;
      3'h5: pad_exp = {1'b1, h, 2'h0};
      3'h7: pad_exp = h ? 4'h0 : 4'h8;
      default: pad_exp = 4'h0;
    endcase
  endfunction : pad_exp

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test;
    end
  end

  initial begin
    {nrst, npor, psel, penable, pwrite, ext, hpc} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rst(1'b1);
    for (int p = 0; p < 5; p++) begin
      get(p[7:0]);
      chk(rd[31:16], {4'h0, DFLT_CFG[p], 8'h00});
    end
    hpc <= 1'b1;
    repeat (3) @(posedge clock);
    chk({pad_drive[2].oe, pad_drive[2].out, pad_drive[3].oe, pad_drive[3].out}, 4'hF);
    hpc <= 1'b0;
    repeat (3) @(posedge clock);
    chk({pad_drive[2].oe, pad_drive[2].out, pad_drive[3].oe, pad_drive[3].out}, 4'hA);
    for (int i = 0; i < 16; i++) begin
      if (i[3:1] == 3'h6) continue;
      set(8'h00, i[0] ? LEVEL_HIGH : LEVEL_LOW, {1'b1, i[3:1]});
      repeat (3) @(posedge clock);
      pd = pad_drive[0];
      pe = pad_exp(i[3:1], i[0]);
      chk({pd.oe, pd.oe & pd.out, pd.pull_up, pd.pull_dn, pd.oe & pd.slow},
          {pe, i[3] & pe[3]});
      get(8'h00);
      chk(rd[31:16], {5'h01, i[3:1], i[0] ? LEVEL_HIGH : LEVEL_LOW});
    end
    cmd(32'h0000_6500, CMD_SET_PIN, LEN_VALUE);
    chk(rd[12:0], {1'b1, LEN_NONE, 8'hE2});
    cmd(32'h0000_0005, CMD_SET_PIN, LEN_VALUE);
    chk(rd[12:0], {1'b1, LEN_NONE, 8'hE2});
    cmd(32'h0000_3200, CMD_SET_PIN, LEN_VALUE);
    get(8'h00);
    chk(rd[31:16], 16'h0F32);
    set(8'h00, 8'h32, 4'h9);
    n = 0;
    repeat (400) begin
      @(posedge clock);
      n += pad_drive[0].out;
    end
    chk(n, 200);
    set(8'h00, LEVEL_LOW, 4'hA);
    repeat (100) @(posedge clock);
    get(8'h00);
    ext <= 1'b1;
    repeat (100) @(posedge clock);
    get(8'h00);
    chk(rd[15:8], 8'h05);
    chk({hps, owr}, 2'h3);
    get(8'h00);
    chk(rd[15:8], 8'h01);
    ext <= 1'b0;
    repeat (100) @(posedge clock);
    get(8'h00);
    chk(rd[15:8], 8'h02);
    chk({hps, owr}, 2'h0);
    bus(1'b0, ADDR_LEVELS, 32'h0000_0000);
    chk(rd[4:0], 5'h00);
    bus(1'b0, 12'h020, 32'h0000_0000);
    chk({err, rd}, {1'b1, 32'h0000_0000});
    set(8'h03, LEVEL_HIGH, 4'hD);
    cmd(32'h0000_0000, CMD_STORE_BOOT, LEN_NONE);
    chk(rd[12:0], {1'b1, LEN_NONE, 8'h44});
    bus(1'b0, ADDR_CMD, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    rst(1'b0);
    get(8'h03);
    chk(rd[31:16], 16'h0D64);
    rst(1'b1);
    get(8'h03);
    chk(rd[31:16], 16'h0100);
    finish_test;
  end
endmodule : gpio_command_config_readback_tb
